/* inc/lfcs_pkg.sv */
package lfcs_pkg;

  // Byte width of every stored configuration byte
  localparam int unsigned CFG_W = 8;

  // Which stored byte a programmer command addresses
  typedef enum logic [1:0] {
    CFG_LOCK = 2'b00,
    CFG_EXT = 2'b01,
    CFG_HIGH = 2'b10,
    CFG_LOW = 2'b11
  } lfcs_cfg_sel_t;

  // Programmer commands; the serial instruction framing is decoded elsewhere
  typedef enum logic [2:0] {
    CMD_NOP = 3'b000,
    CMD_WR_CFG = 3'b001,
    CMD_RD_CFG = 3'b010,
    CMD_RD_IDENT = 3'b011,
    CMD_CHIP_ERASE = 3'b100,
    CMD_MEM_WR = 3'b101,
    CMD_MEM_RD = 3'b110
  } lfcs_cmd_t;

  // Session states of the fuse latch
  typedef enum logic [1:0] {
    SESS_NORMAL = 2'b00,
    SESS_PROG = 2'b01,
    SESS_RELATCH = 2'b10
  } lfcs_sess_t;

  // Lock byte fields; a cleared bit is a programmed bit
  localparam int unsigned LOCK_LOW_BIT = 0;
  localparam int unsigned LOCK_HIGH_BIT = 1;
  localparam logic [7:0] LOCK_USED_MASK = 8'h03;

  // Extended byte fields
  localparam int unsigned EXT_SELF_PROG_BIT = 0;
  localparam logic [7:0] EXT_USED_MASK = 8'h01;

  // High byte fields
  localparam int unsigned HIGH_RST_DIS_BIT = 7;
  localparam int unsigned HIGH_DEBUG_BIT = 6;
  localparam int unsigned HIGH_SERIAL_PROG_BIT = 5;
  localparam int unsigned HIGH_WDOG_BIT = 4;
  localparam int unsigned HIGH_EE_KEEP_BIT = 3;
  localparam int unsigned HIGH_BOD_MSB = 2;
  localparam int unsigned HIGH_BOD_LSB = 0;
  localparam logic [7:0] HIGH_SERIAL_PROG_MASK = 8'h20;

  // Low byte fields
  localparam int unsigned LOW_DIV8_BIT = 7;
  localparam int unsigned LOW_CLOCK_OUTPUT_ENABLE_BIT = 6;
  localparam int unsigned LOW_SUT_MSB = 5;
  localparam int unsigned LOW_SUT_LSB = 4;
  localparam int unsigned LOW_CKSEL_MSB = 3;
  localparam int unsigned LOW_CKSEL_LSB = 0;

  // Factory values of the stored bytes
  localparam logic [7:0] LOCK_DEFAULT = 8'hff;
  localparam logic [7:0] EXT_DEFAULT = 8'hff;
  localparam logic [7:0] HIGH_DEFAULT = 8'hdf;
  localparam logic [7:0] LOW_DEFAULT = 8'h62;

  // Identification space addresses; the last slot returns the calibration byte
  localparam logic [1:0] IDENT_ADDR_0 = 2'h0;
  localparam logic [1:0] IDENT_ADDR_1 = 2'h1;
  localparam logic [1:0] IDENT_ADDR_2 = 2'h2;
  localparam logic [1:0] IDENT_ADDR_CAL = 2'h3;

  // Software pointer values for reading the configuration bytes
  localparam logic [15:0] SW_PTR_LOW = 16'h0000;
  localparam logic [15:0] SW_PTR_LOCK = 16'h0001;
  localparam logic [15:0] SW_PTR_EXT = 16'h0002;
  localparam logic [15:0] SW_PTR_HIGH = 16'h0003;

  // Cycles after arming in which a load still returns a configuration byte
  localparam logic [1:0] SW_LOAD_WINDOW = 2'h3;

endpackage

/* logic/lfcs_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module lfcs_sync import lfcs_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Pin level and its filtered copy
  input wire logic async_in,
  output logic level_q
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  // Three stage chain; only the second stage reads the first
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= async_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Accept a new level only once two stages agree, rejecting single glitches
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      level_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end

endmodule

`default_nettype wire

/* logic/lfcs_nv_store.sv */
`timescale 1ns/1ps
`default_nettype none

module lfcs_nv_store import lfcs_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Write port
  input wire logic wr_en,
  input wire logic [1:0] wr_sel,
  input wire logic [7:0] wr_data,
  input wire logic erase_lock,
  // Stored bytes, all registered
  output logic [7:0] lock_q,
  output logic [7:0] ext_q,
  output logic [7:0] high_q,
  output logic [7:0] low_q
);

  // Reset stands in for the factory state of the cells
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      lock_q <= LOCK_DEFAULT;
      ext_q <= EXT_DEFAULT;
      high_q <= HIGH_DEFAULT;
      low_q <= LOW_DEFAULT;
    end else if (erase_lock) begin
      lock_q <= LOCK_DEFAULT; // Fuse bytes untouched by erase
    end else if (wr_en) begin
      case (lfcs_cfg_sel_t'(wr_sel))
        CFG_LOCK: lock_q <= wr_data;
        CFG_EXT: ext_q <= wr_data;
        CFG_HIGH: high_q <= wr_data;
        CFG_LOW: low_q <= wr_data;
        default: lock_q <= lock_q;
      endcase
    end
  end

endmodule

`default_nettype wire

/* logic/lfcs_top.sv */
`timescale 1ns/1ps
`default_nettype none

module lfcs_top import lfcs_pkg::*; #(
  parameter logic [7:0] IDENT_BYTE_0 = 8'h5a, // Arbitrary value
  parameter logic [7:0] IDENT_BYTE_1 = 8'h3c, // Arbitrary value
  parameter logic [7:0] IDENT_BYTE_2 = 8'h66, // Arbitrary value
  parameter logic [7:0] OSC_CAL_BYTE = 8'h80
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Programmer pins
  input wire logic prog_mode_pin,
  input wire logic hv_mode_pin,
  // Programmer command
  input wire logic prog_cmd_valid,
  input wire logic [2:0] prog_cmd,
  input wire logic [1:0] prog_addr,
  input wire logic [7:0] prog_wdata,
  // Programmer answer
  output logic prog_done_q,
  output logic prog_refused_q,
  output logic [7:0] prog_rdata_q,
  output logic mem_grant_q,
  output logic flash_erase_q,
  output logic eeprom_erase_q,
  output logic in_prog_q,
  // Software configuration read
  input wire logic sw_ctrl_wr,
  input wire logic sw_read_fuse_lock_ctrl,
  input wire logic sw_store_prog_enable_ctrl,
  input wire logic [15:0] sw_ptr,
  input wire logic program_memory_load_instr,
  output logic read_fuse_lock_ctrl_q,
  output logic store_prog_enable_ctrl_q,
  output logic sw_rvalid_q,
  output logic [7:0] sw_rdata_q,
  // Configuration to the rest of the chip; fuse bytes latched, lock bits and EEPROM-keep live
  output logic [7:0] cfg_ext_q,
  output logic [7:0] cfg_high_q,
  output logic [7:0] cfg_low_q,
  output logic [1:0] lock_bits_q,
  output logic eeprom_preserve_q,
  output logic debug_if_enable_q,
  output logic debug_pm_read_q,
  output logic [7:0] rc_osc_calibration_reg_q
);

  logic prog_pin_s;
  logic hv_pin_s;
  logic [7:0] nv_lock;
  logic [7:0] nv_ext;
  logic [7:0] nv_high;
  logic [7:0] nv_low;
  logic nv_wr_en;
  logic [1:0] nv_wr_sel;
  logic [7:0] nv_wr_data;
  logic nv_erase_lock;
  logic taken;
  logic lock_low_prog;
  logic lock_high_prog;
  logic refuse_d;
  logic grant_d;
  logic flash_erase_d;
  logic eeprom_erase_d;
  logic [7:0] rdata_d;
  logic latch_en;
  logic sw_armed;
  logic sw_hit;
  logic [7:0] sw_byte;
  logic [1:0] win_q;
  lfcs_sess_t sess_q;
  lfcs_cmd_t cmd;

  // Pins come from the programmer, outside this clock
  lfcs_sync u_sync_prog (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .async_in(prog_mode_pin),
    .level_q(prog_pin_s)
  );

  lfcs_sync u_sync_hv (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .async_in(hv_mode_pin),
    .level_q(hv_pin_s)
  );

  lfcs_nv_store u_nv (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .wr_en(nv_wr_en),
    .wr_sel(nv_wr_sel),
    .wr_data(nv_wr_data),
    .erase_lock(nv_erase_lock),
    .lock_q(nv_lock),
    .ext_q(nv_ext),
    .high_q(nv_high),
    .low_q(nv_low)
  );

  // Protection decode from the live lock byte
  assign cmd = lfcs_cmd_t'(prog_cmd);
  assign lock_low_prog = ~nv_lock[LOCK_LOW_BIT];
  assign lock_high_prog = ~nv_lock[LOCK_HIGH_BIT];
  assign taken = prog_cmd_valid && (sess_q == SESS_PROG);

  // Command decode; stored bytes are kept active low so reads need no inversion
  always_comb begin
    nv_wr_en = 1'b0;
    nv_wr_sel = prog_addr;
    nv_wr_data = prog_wdata;
    nv_erase_lock = 1'b0;
    refuse_d = 1'b0;
    grant_d = 1'b0;
    flash_erase_d = 1'b0;
    eeprom_erase_d = 1'b0;
    rdata_d = 8'hff;
    if (taken) begin
      case (cmd)
        CMD_WR_CFG: begin
          if (lfcs_cfg_sel_t'(prog_addr) == CFG_LOCK) begin
            nv_wr_en = 1'b1;
            nv_wr_data = nv_lock & (prog_wdata | ~LOCK_USED_MASK);
          end else if (lock_low_prog) begin
            refuse_d = 1'b1;
          end else begin
            nv_wr_en = 1'b1;
            case (lfcs_cfg_sel_t'(prog_addr))
              CFG_EXT: nv_wr_data = prog_wdata | ~EXT_USED_MASK;
              CFG_HIGH: begin
                if (!hv_pin_s) begin
                  nv_wr_data = (prog_wdata & ~HIGH_SERIAL_PROG_MASK)
                    | (nv_high & HIGH_SERIAL_PROG_MASK);
                end
              end
              default: nv_wr_data = prog_wdata;
            endcase
          end
        end
        CMD_RD_CFG: begin
          case (lfcs_cfg_sel_t'(prog_addr))
            CFG_LOCK: rdata_d = nv_lock;
            CFG_EXT: rdata_d = nv_ext;
            CFG_HIGH: rdata_d = nv_high;
            default: rdata_d = nv_low;
          endcase
        end
        CMD_RD_IDENT: begin
          // No lock check here: identity stays readable when locked
          case (prog_addr)
            IDENT_ADDR_0: rdata_d = IDENT_BYTE_0;
            IDENT_ADDR_1: rdata_d = IDENT_BYTE_1;
            IDENT_ADDR_2: rdata_d = IDENT_BYTE_2;
            default: rdata_d = OSC_CAL_BYTE;
          endcase
        end
        CMD_CHIP_ERASE: begin
          nv_erase_lock = 1'b1;
          flash_erase_d = 1'b1;
          eeprom_erase_d = nv_high[HIGH_EE_KEEP_BIT];
        end
        CMD_MEM_WR: begin
          refuse_d = lock_low_prog | lock_high_prog;
          grant_d = ~(lock_low_prog | lock_high_prog);
        end
        CMD_MEM_RD: begin
          refuse_d = lock_high_prog;
          grant_d = ~lock_high_prog;
        end
        default: refuse_d = 1'b1;
      endcase
    end
  end

  // Answer to the programmer, one cycle after the command is taken
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prog_done_q <= 1'b0;
      prog_refused_q <= 1'b0;
      prog_rdata_q <= 8'hff;
      mem_grant_q <= 1'b0;
      flash_erase_q <= 1'b0;
      eeprom_erase_q <= 1'b0;
    end else begin
      prog_done_q <= taken;
      prog_refused_q <= refuse_d;
      prog_rdata_q <= rdata_d;
      mem_grant_q <= grant_d;
      flash_erase_q <= flash_erase_d;
      eeprom_erase_q <= eeprom_erase_d;
    end
  end

  // Session tracking; reset lands in the relatch state so power-up captures
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sess_q <= SESS_RELATCH;
    end else begin
      case (sess_q)
        SESS_NORMAL: if (prog_pin_s) sess_q <= SESS_PROG;
        SESS_PROG: if (!prog_pin_s) sess_q <= SESS_RELATCH;
        SESS_RELATCH: sess_q <= prog_pin_s ? SESS_PROG : SESS_NORMAL;
        default: sess_q <= SESS_RELATCH;
      endcase
    end
  end

  assign latch_en = (sess_q == SESS_RELATCH) || ((sess_q == SESS_NORMAL) && prog_pin_s);

  // Capture fuses on entry, after exit and at power-up; hold them in between
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      cfg_ext_q <= EXT_DEFAULT;
      cfg_high_q <= HIGH_DEFAULT;
      cfg_low_q <= LOW_DEFAULT;
    end else if (latch_en) begin
      cfg_ext_q <= nv_ext;
      cfg_high_q <= nv_high;
      cfg_low_q <= nv_low;
    end
  end

  // Session flag, live EEPROM-keep and lock view
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      in_prog_q <= 1'b0;
      eeprom_preserve_q <= 1'b0;
      lock_bits_q <= LOCK_DEFAULT[1:0];
    end else begin
      in_prog_q <= (sess_q == SESS_PROG);
      eeprom_preserve_q <= ~nv_high[HIGH_EE_KEEP_BIT];
      lock_bits_q <= nv_lock[LOCK_HIGH_BIT:LOCK_LOW_BIT];
    end
  end

  // Debug link gating; program read over debug survives the lock bits
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      debug_if_enable_q <= 1'b0;
      debug_pm_read_q <= 1'b0;
    end else begin
      debug_if_enable_q <= ~cfg_high_q[HIGH_DEBUG_BIT]
        & ~lock_low_prog & ~lock_high_prog;
      debug_pm_read_q <= ~cfg_high_q[HIGH_DEBUG_BIT];
    end
  end

  // Calibration copy; reset is the only loader so every reset refreshes it
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rc_osc_calibration_reg_q <= OSC_CAL_BYTE;
    end else begin
      rc_osc_calibration_reg_q <= rc_osc_calibration_reg_q;
    end
  end

  // Software read path: pointer selects which configuration byte
  assign sw_armed = read_fuse_lock_ctrl_q && store_prog_enable_ctrl_q && (win_q != 2'h0);
  always_comb begin
    sw_hit = 1'b1;
    case (sw_ptr)
      SW_PTR_LOCK: sw_byte = nv_lock;
      SW_PTR_LOW: sw_byte = nv_low;
      SW_PTR_HIGH: sw_byte = nv_high;
      SW_PTR_EXT: sw_byte = nv_ext;
      default: begin
        sw_byte = 8'hff;
        sw_hit = 1'b0;
      end
    endcase
  end

  // Control bits auto-clear on a completed load or when the window runs out
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      read_fuse_lock_ctrl_q <= 1'b0;
      store_prog_enable_ctrl_q <= 1'b0;
      win_q <= 2'h0;
    end else if (sw_ctrl_wr) begin
      read_fuse_lock_ctrl_q <= sw_read_fuse_lock_ctrl;
      store_prog_enable_ctrl_q <= sw_store_prog_enable_ctrl;
      win_q <= SW_LOAD_WINDOW;
    end else if ((sw_armed && program_memory_load_instr) || (win_q == 2'h1)) begin
      read_fuse_lock_ctrl_q <= 1'b0;
      store_prog_enable_ctrl_q <= 1'b0;
      win_q <= 2'h0;
    end else if (win_q != 2'h0) begin
      win_q <= win_q - 2'h1;
    end
  end

  // Load result to the destination register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      sw_rvalid_q <= 1'b0;
      sw_rdata_q <= 8'hff;
    end else begin
      sw_rvalid_q <= sw_armed && program_memory_load_instr && sw_hit;
      sw_rdata_q <= sw_byte;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  sequence s_sw_arm;
    sw_ctrl_wr && sw_read_fuse_lock_ctrl && sw_store_prog_enable_ctrl;
  endsequence

  sequence s_no_load3;
    (!program_memory_load_instr && !sw_ctrl_wr) [*3];
  endsequence

  property p_lock_only_erase;
    !(taken && cmd == CMD_CHIP_ERASE) |=> (nv_lock & ~$past(nv_lock)) == 8'h00;
  endproperty
  a_lock_only_erase: assert property (p_lock_only_erase)
    else $error("lock bit unprogrammed without chip erase");

  property p_open_write;
    taken && cmd == CMD_MEM_WR && nv_lock[1:0] == 2'b11 |=> mem_grant_q && !prog_refused_q;
  endproperty
  a_open_write: assert property (p_open_write)
    else $error("write refused with no lock");

  property p_mode2_write;
    taken && cmd == CMD_MEM_WR && nv_lock[1:0] == 2'b10 |=> prog_refused_q && !mem_grant_q;
  endproperty
  a_mode2_write: assert property (p_mode2_write)
    else $error("write granted in mode 2");

  property p_mode3_read;
    taken && cmd == CMD_MEM_RD && nv_lock[1:0] == 2'b00 |=> prog_refused_q && !mem_grant_q;
  endproperty
  a_mode3_read: assert property (p_mode3_read)
    else $error("read granted in mode 3");

  property p_erase_keeps_fuses;
    taken && cmd == CMD_CHIP_ERASE |=> $stable(nv_high) && $stable(nv_low) && $stable(nv_ext)
      && nv_lock == LOCK_DEFAULT;
  endproperty
  a_erase_keeps_fuses: assert property (p_erase_keeps_fuses)
    else $error("chip erase altered a fuse");

  property p_fuse_locked;
    taken && cmd == CMD_WR_CFG && prog_addr != 2'b00 && lock_low_prog
      |=> prog_refused_q ##1 $stable(nv_high);
  endproperty
  a_fuse_locked: assert property (p_fuse_locked)
    else $error("fuse changed while locked");

  property p_hold_in_prog;
    sess_q == SESS_PROG ##1 sess_q == SESS_PROG |-> $stable(cfg_high_q) && $stable(cfg_low_q);
  endproperty
  a_hold_in_prog: assert property (p_hold_in_prog)
    else $error("latched fuses moved inside session");

  property p_serial_keeps_serial_prog_enable_fuse;
    taken && cmd == CMD_WR_CFG && prog_addr == 2'b10 && !hv_pin_s
      |=> $stable(nv_high[HIGH_SERIAL_PROG_BIT]);
  endproperty
  a_serial_keeps_serial_prog_enable_fuse: assert property (p_serial_keeps_serial_prog_enable_fuse)
    else $error("serial write changed serial enable fuse");

  property p_eeprom_keep;
    taken && cmd == CMD_CHIP_ERASE && !nv_high[HIGH_EE_KEEP_BIT] |=> flash_erase_q && !eeprom_erase_q;
  endproperty
  a_eeprom_keep: assert property (p_eeprom_keep)
    else $error("EEPROM erased while preserved");

  property p_ident_locked;
    taken && cmd == CMD_RD_IDENT && prog_addr == 2'b00 |=> !prog_refused_q
      && prog_rdata_q == IDENT_BYTE_0;
  endproperty
  a_ident_locked: assert property (p_ident_locked)
    else $error("identity byte not returned");

  property p_sw_window;
    s_sw_arm ##1 s_no_load3 |=> !read_fuse_lock_ctrl_q && !store_prog_enable_ctrl_q;
  endproperty
  a_sw_window: assert property (p_sw_window)
    else $error("control bits did not auto-clear");

endmodule

`default_nettype wire

/* verif/lfcs_prog_model.sv */
`timescale 1ns/1ps
`default_nettype none

module lfcs_prog_model import lfcs_pkg::*; (
  // Clock
  input wire logic sys_clk,
  // Session pins and command
  output logic prog_mode_pin,
  output logic hv_mode_pin,
  output logic prog_cmd_valid,
  output logic [2:0] prog_cmd,
  output logic [1:0] prog_addr,
  output logic [7:0] prog_wdata,
  // Answer from the store
  input wire logic prog_done_q,
  input wire logic prog_refused_q,
  input wire logic [7:0] prog_rdata_q
);
  // Idle at power-up; high-voltage mode so a disabled reset pin never strands us
  initial begin
    prog_mode_pin = 1'b0;
    hv_mode_pin = 1'b1;
    prog_cmd_valid = 1'b0;
    prog_cmd = CMD_NOP;
    prog_addr = 2'h0;
    prog_wdata = 8'h00;
  end

  // Pins move, then the store's input filter needs a few cycles to follow
  task automatic set_pins(input logic mode, input logic hv);
    @(negedge sys_clk);
    prog_mode_pin = mode;
    hv_mode_pin = hv;
    repeat (8) @(negedge sys_clk);
  endtask

  // One command; the answer stands only in the cycle after the taking edge
  task automatic run(input logic [2:0] cmd, input logic [1:0] addr, input logic [7:0] wd,
    output logic done, output logic refused, output logic [7:0] rd);
    @(negedge sys_clk);
    prog_cmd_valid = 1'b1;
    prog_cmd = cmd;
    prog_addr = addr;
    prog_wdata = wd;
    @(posedge sys_clk);
    @(negedge sys_clk);
    done = prog_done_q;
    refused = prog_refused_q;
    rd = prog_rdata_q;
    // Released address and data lines show junk, never the stale value; the command keeps its last value
    prog_cmd_valid = 1'b0;
    prog_addr = ~addr;
    prog_wdata = ~wd;
  endtask
endmodule

`default_nettype wire

/* verif/lfcs_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module lfcs_top_tb import lfcs_pkg::*;;
  // Arbitrary identity values; last slot is the calibration byte
  localparam logic [7:0] IDV [4] = '{8'hc3, 8'h4e, 8'h17, 8'ha5};
  localparam logic [7:0] DEF [4] = '{8'hff, 8'hff, 8'hdf, 8'h62};
  localparam logic [7:0] NEWV [4] = '{8'hff, 8'hfe, 8'h97, 8'he4};
  // Software reads: pointer, load delay, valid, data
  localparam logic [19:0] SWT [6] = '{20'h111fc, 20'h021e4, 20'h31197, 20'h211fe,
    20'h14000, 20'h41000};
  logic sys_clk, rstn, prog_mode_pin, hv_mode_pin, prog_cmd_valid;
  logic [2:0] prog_cmd;
  logic [1:0] prog_addr, lock_bits_q;
  logic [7:0] prog_wdata, prog_rdata_q, sw_rdata_q, rd, rc_osc_calibration_reg_q;
  logic prog_done_q, prog_refused_q, mem_grant_q, flash_erase_q, eeprom_erase_q, in_prog_q;
  logic sw_ctrl_wr, sw_read_fuse_lock_ctrl, sw_store_prog_enable_ctrl;
  logic program_memory_load_instr, read_fuse_lock_ctrl_q, store_prog_enable_ctrl_q;
  logic sw_rvalid_q, eeprom_preserve_q, debug_if_enable_q, debug_pm_read_q;
  logic [15:0] sw_ptr;
  logic [7:0] cfg_ext_q, cfg_high_q, cfg_low_q;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;

  lfcs_top #(.IDENT_BYTE_0(IDV[0]), .IDENT_BYTE_1(IDV[1]), .IDENT_BYTE_2(IDV[2]),
    .OSC_CAL_BYTE(IDV[3])) dut (
    .sys_clk, .rstn, .prog_mode_pin, .hv_mode_pin, .prog_cmd_valid, .prog_cmd, .prog_addr,
    .prog_wdata, .prog_done_q, .prog_refused_q, .prog_rdata_q, .mem_grant_q, .flash_erase_q,
    .eeprom_erase_q, .in_prog_q, .sw_ctrl_wr, .sw_read_fuse_lock_ctrl,
    .sw_store_prog_enable_ctrl, .sw_ptr, .program_memory_load_instr, .read_fuse_lock_ctrl_q,
    .store_prog_enable_ctrl_q, .sw_rvalid_q, .sw_rdata_q, .cfg_ext_q, .cfg_high_q,
    .cfg_low_q, .lock_bits_q, .eeprom_preserve_q, .debug_if_enable_q, .debug_pm_read_q,
    .rc_osc_calibration_reg_q);

  lfcs_prog_model prog (
    .sys_clk, .prog_mode_pin, .hv_mode_pin, .prog_cmd_valid, .prog_cmd, .prog_addr,
    .prog_wdata, .prog_done_q, .prog_refused_q, .prog_rdata_q);

  // 200 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Hang guard, well above the 150 or so cycles the run needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask

  task automatic tdone(input string name);
    $display("test %s finished", name);
  endtask

  // Status byte: done, refused, grant (memory commands only), flash erase, eeprom erase
  task automatic pc(input logic [2:0] c, input logic [1:0] a, input logic [7:0] w,
    input logic [7:0] es);
    logic d, r;
    prog.run(c, a, w, d, r, rd);
    chk({3'h0, d, r, mem_grant_q & c[2] & (c != CMD_CHIP_ERASE), flash_erase_q,
      eeprom_erase_q}, es, "cmd status");
  endtask

  // Arm both control bits, load k cycles later; controls must be clear afterwards
  task automatic swrd(input logic [15:0] p, input logic [3:0] k, input logic v,
    input logic [7:0] e);
    sw_ctrl_wr = 1'b1;
    sw_read_fuse_lock_ctrl = 1'b1;
    sw_store_prog_enable_ctrl = 1'b1;
    @(negedge sys_clk);
    sw_ctrl_wr = 1'b0;
    repeat (k - 1) @(negedge sys_clk);
    program_memory_load_instr = 1'b1;
    sw_ptr = p;
    @(negedge sys_clk);
    program_memory_load_instr = 1'b0;
    chk({5'h0, sw_rvalid_q, read_fuse_lock_ctrl_q, store_prog_enable_ctrl_q}, {5'h0, v, 2'b00},
      "sw control");
    if (v) begin
      chk(sw_rdata_q, e, "sw data");
    end
    @(negedge sys_clk);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    rstn = 1'b0;
    sw_ctrl_wr = 1'b0;
    sw_read_fuse_lock_ctrl = 1'b0;
    sw_store_prog_enable_ctrl = 1'b0;
    sw_ptr = 16'h0000;
    program_memory_load_instr = 1'b0;
    repeat (6) @(negedge sys_clk);
    chk(cfg_ext_q, 8'hff, "ext default");
    chk(cfg_high_q, 8'hdf, "high default");
    chk(cfg_low_q, 8'h62, "low default");
    chk({6'h3f, lock_bits_q}, 8'hff, "lock default");
    rstn = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk(rc_osc_calibration_reg_q, IDV[3], "calibration");
    tdone("reset");
    prog.set_pins(1'b1, 1'b1);
    chk({7'h0, in_prog_q}, 8'h01, "session");
    for (int i = 0; i < 4; i++) begin
      pc(CMD_RD_IDENT, 2'(i), 8'h00, 8'h10);
      chk(rd, IDV[i], "ident");
      pc(CMD_RD_CFG, 2'(i), 8'h00, 8'h10);
      chk(rd, DEF[i], "cfg read");
    end
    pc(CMD_CHIP_ERASE, 2'h0, 8'h00, 8'h13);
    // Fuse bytes go in before any lock bit
    pc(CMD_WR_CFG, CFG_HIGH, 8'h97, 8'h10);
    @(negedge sys_clk);
    chk({7'h0, eeprom_preserve_q}, 8'h01, "keep acts at once");
    chk(cfg_high_q, 8'hdf, "latched high held");
    pc(CMD_WR_CFG, CFG_LOW, 8'he4, 8'h10);
    pc(CMD_WR_CFG, CFG_EXT, 8'h00, 8'h10);
    pc(CMD_CHIP_ERASE, 2'h0, 8'h00, 8'h12);
    for (int i = 0; i < 4; i++) begin
      pc(CMD_RD_CFG, 2'(i), 8'h00, 8'h10);
      chk(rd, NEWV[i], "fuses after erase");
    end
    prog.set_pins(1'b1, 1'b0);
    pc(CMD_WR_CFG, CFG_HIGH, 8'hb7, 8'h10);
    pc(CMD_RD_CFG, CFG_HIGH, 8'h00, 8'h10);
    chk(rd, 8'h97, "serial enable kept");
    prog.set_pins(1'b1, 1'b1);
    tdone("fuses");
    pc(CMD_MEM_WR, 2'h0, 8'h5a, 8'h14);
    pc(CMD_WR_CFG, CFG_LOCK, 8'hfe, 8'h10);
    @(negedge sys_clk);
    chk({6'h3f, lock_bits_q}, 8'hfe, "mode two");
    pc(CMD_MEM_WR, 2'h0, 8'h5a, 8'h18);
    pc(CMD_MEM_RD, 2'h0, 8'h00, 8'h14);
    pc(CMD_WR_CFG, CFG_HIGH, 8'hff, 8'h18);
    pc(CMD_WR_CFG, CFG_LOCK, 8'h00, 8'h10);
    pc(CMD_RD_CFG, CFG_LOCK, 8'h00, 8'h10);
    chk(rd, 8'hfc, "lock unused bits");
    pc(CMD_MEM_RD, 2'h0, 8'h00, 8'h18);
    pc(CMD_RD_IDENT, 2'h1, 8'h00, 8'h10);
    chk(rd, IDV[1], "ident while locked");
    prog.set_pins(1'b0, 1'b1);
    chk(cfg_high_q, 8'h97, "relatched high");
    chk({6'h0, debug_pm_read_q, debug_if_enable_q}, 8'h02, "debug locked");
    tdone("locks");
    for (int i = 0; i < 6; i++) begin
      swrd({12'h0, SWT[i][19:16]}, SWT[i][15:12], SWT[i][8], SWT[i][7:0]);
    end
    tdone("software");
    prog.set_pins(1'b1, 1'b1);
    pc(CMD_CHIP_ERASE, 2'h0, 8'h00, 8'h12);
    pc(CMD_RD_CFG, CFG_LOCK, 8'h00, 8'h10);
    chk(rd, 8'hff, "lock erased");
    pc(CMD_MEM_WR, 2'h0, 8'h5a, 8'h14);
    prog.set_pins(1'b0, 1'b1);
    chk({7'h0, debug_if_enable_q}, 8'h01, "debug open");
    tdone("erase");
    end_of_test();
  end
endmodule

`default_nettype wire
